// *** att_regs.sv ***
// Purpose: APB register bank and timing for AFE gain and offset tuning
// Assumes: Single clock; auto DAC codes come from the loop as inputs
// Notes: Zero wait states; unmapped addresses read zero and flag pslverr
//
// Behaviour
// - One gain period drives both gain controllers; update every period x 2us.
// - Gain period zero stops all gain DAC updates.
// - Coarse override bit 15 forces coarse offset to bits 7:0; auto stops.
// - Fine override bit 15 forces fine offset to bits 7:0.
// - Override values are 8-bit two's complement, 250 uV per step.
// - Both offset controllers update every offset period x 2us.
// - Offset period zero stops all auto offset DAC updates; overrides still apply.
// - Extrapolator runs extrapolation time x 2us after a qualifying event.
// - Extrapolation time zero means the extrapolator never runs.
// - Sleep to functional waits functional wake settle cycles.
// - Startup settle count is 19 bits split over two registers.
// - Sequencing is held in reset during the startup settle count.
// - Battery sleep to low power holds DSP reset for its settle count.
// - Gain period resets 0x01F4; overrides reset zero, auto active.
module att_regs
   import att_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] auto_coarse_gain,
   input wire logic [5:0] auto_fine_gain,
   input wire att_offset_s auto_offset,
   output logic [5:0] coarse_gain_dac,
   output logic [5:0] fine_gain_dac,
   output att_offset_s offset_dac,
   output logic extrap_run,
   output logic seq_reset,
   output logic dsp_reset
);
   logic [15:0] gain_per_q, coarse_ovr_q, fine_ovr_q, ofs_per_q;
   logic [15:0] extrp_q, func_wake_q, start_lo_q, lp_wake_q;
   logic [2:0] start_hi_q, ctrl_q;
   logic [18:0] startup_cnt;
   att_state_e state_q;
   logic gain_stb, ofs_stb, extrp_stb;
   logic start_busy, fwake_busy, lwake_busy;
   logic start_load_q, fwake_load, lwake_load;
   logic sleep_req_q, qual_q, qual_d;
   logic [15:0] extrp_left_q;
   logic wr_en, rd_en;
   logic [7:0] idx;
   logic [31:0] rd_d;
   logic hit_d;
   default clocking cb_main @(posedge clk); endclocking
   default disable iff (!nrst);

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] st);
      merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   assign idx = paddr[9:2];
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign startup_cnt = {start_hi_q, start_lo_q};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gain_per_q <= RST_GAIN_PER;
         coarse_ovr_q <= RST_OVR;
         fine_ovr_q <= RST_OVR;
         ofs_per_q <= RST_OFS_PER;
         extrp_q <= RST_EXTRP;
         func_wake_q <= RST_FUNC_WAKE;
         start_hi_q <= RST_START_HI;
         start_lo_q <= RST_START_LO;
         lp_wake_q <= RST_LP_WAKE;
         ctrl_q <= 3'h0;
      end else if (wr_en && paddr[1:0] == 2'h0) begin
         if (idx == IDX_GAIN_PER) begin
            gain_per_q <= merge16(gain_per_q, pwdata, pstrb);
         end else if (idx == IDX_COARSE_OVR) begin
            coarse_ovr_q <= merge16(coarse_ovr_q, pwdata, pstrb) & 16'h80FF;
         end else if (idx == IDX_FINE_OVR) begin
            fine_ovr_q <= merge16(fine_ovr_q, pwdata, pstrb) & 16'h80FF;
         end else if (idx == IDX_OFS_PER) begin
            ofs_per_q <= merge16(ofs_per_q, pwdata, pstrb);
         end else if (idx == IDX_EXTRP) begin
            extrp_q <= merge16(extrp_q, pwdata, pstrb);
         end else if (idx == IDX_FUNC_WAKE) begin
            func_wake_q <= merge16(func_wake_q, pwdata, pstrb);
         end else if (idx == IDX_START_HI) begin
            if (pstrb[0]) begin
               start_hi_q <= pwdata[2:0];
            end
         end else if (idx == IDX_START_LO) begin
            start_lo_q <= merge16(start_lo_q, pwdata, pstrb);
         end else if (idx == IDX_LP_WAKE) begin
            lp_wake_q <= merge16(lp_wake_q, pwdata, pstrb);
         end else if (idx == IDX_CTRL) begin
            if (pstrb[0]) begin
               ctrl_q <= pwdata[2:0];
            end
         end
      end
   end

   // Read data is staged in setup so the access phase needs no wait
   always_comb begin
      rd_d = 32'h00000000;
      hit_d = 1'b1;
      if (paddr[1:0] != 2'h0) begin
         hit_d = 1'b0;
      end else if (idx == IDX_GAIN_PER) begin
         rd_d = {16'h0000, gain_per_q};
      end else if (idx == IDX_COARSE_OVR) begin
         rd_d = {16'h0000, coarse_ovr_q};
      end else if (idx == IDX_FINE_OVR) begin
         rd_d = {16'h0000, fine_ovr_q};
      end else if (idx == IDX_OFS_PER) begin
         rd_d = {16'h0000, ofs_per_q};
      end else if (idx == IDX_EXTRP) begin
         rd_d = {16'h0000, extrp_q};
      end else if (idx == IDX_FUNC_WAKE) begin
         rd_d = {16'h0000, func_wake_q};
      end else if (idx == IDX_START_HI) begin
         rd_d = {29'h00000000, start_hi_q};
      end else if (idx == IDX_START_LO) begin
         rd_d = {16'h0000, start_lo_q};
      end else if (idx == IDX_LP_WAKE) begin
         rd_d = {16'h0000, lp_wake_q};
      end else if (idx == IDX_CTRL) begin
         rd_d = {29'h00000000, ctrl_q};
      end else if (idx == IDX_STATUS) begin
         rd_d = {24'h000000, extrap_run, dsp_reset, seq_reset, 2'h0, state_q};
      end else begin
         hit_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= rd_en ? rd_d : 32'h00000000;
         pslverr <= !hit_d;
      end
   end

   // Ready is registered from the setup phase, so it is high in each access phase: zero wait states
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   att_tick u_gain_tick (
      .clk(clk),
      .nrst(nrst),
      .run(!seq_reset),
      .period(gain_per_q),
      .strobe(gain_stb)
   );

   att_tick u_ofs_tick (
      .clk(clk),
      .nrst(nrst),
      .run(!seq_reset),
      .period(ofs_per_q),
      .strobe(ofs_stb)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         coarse_gain_dac <= 6'h00;
         fine_gain_dac <= 6'h00;
      end else if (gain_stb && gain_per_q != 16'h0000) begin
         coarse_gain_dac <= auto_coarse_gain;
         fine_gain_dac <= auto_fine_gain;
      end
   end

   // Overrides act at once; auto codes land only on the offset strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         offset_dac <= '0;
      end else begin
         if (coarse_ovr_q[OVR_EN_BIT]) begin
            offset_dac.coarse <= coarse_ovr_q[7:0];
         end else if (ofs_stb && ofs_per_q != 16'h0000) begin
            offset_dac.coarse <= auto_offset.coarse;
         end
         if (fine_ovr_q[OVR_EN_BIT]) begin
            offset_dac.fine <= fine_ovr_q[7:0];
         end else if (ofs_stb && ofs_per_q != 16'h0000) begin
            offset_dac.fine <= auto_offset.fine;
         end
      end
   end

   // Qualifying event is a rising edge of the control bit
   assign qual_d = ctrl_q[CTRL_QUAL_BIT];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         qual_q <= 1'b0;
      end else begin
         qual_q <= qual_d;
      end
   end

   logic [6:0] xsub_q;
   assign extrp_stb = (xsub_q == TICK_CYC - 7'h01);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         xsub_q <= 7'h00;
         extrp_left_q <= 16'h0000;
         extrap_run <= 1'b0;
      end else if (qual_d && !qual_q && extrp_q != 16'h0000) begin
         xsub_q <= 7'h00;
         extrp_left_q <= extrp_q;
         extrap_run <= 1'b1;
      end else if (extrp_left_q == 16'h0000) begin
         xsub_q <= 7'h00;
         extrap_run <= 1'b0;
      end else if (extrp_stb) begin
         xsub_q <= 7'h00;
         extrp_left_q <= extrp_left_q - 16'h0001;
         extrap_run <= (extrp_left_q != 16'h0001);
      end else begin
         xsub_q <= xsub_q + 7'h01;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sleep_req_q <= 1'b0;
         start_load_q <= 1'b1;
      end else begin
         sleep_req_q <= ctrl_q[CTRL_SLEEP_BIT];
         // Settle write during startup restarts the wait at the new count
         start_load_q <= wr_en && state_q == ATT_STARTUP
            && (idx == IDX_START_HI || idx == IDX_START_LO);
      end
   end

   assign fwake_load = (state_q == ATT_SLEEP) && !ctrl_q[CTRL_SLEEP_BIT]
      && !ctrl_q[CTRL_BATT_BIT];
   assign lwake_load = (state_q == ATT_SLEEP) && !ctrl_q[CTRL_SLEEP_BIT]
      && ctrl_q[CTRL_BATT_BIT];

   att_settle u_start (
      .clk(clk),
      .nrst(nrst),
      .load(start_load_q),
      .count(startup_cnt),
      .busy(start_busy)
   );

   att_settle u_fwake (
      .clk(clk),
      .nrst(nrst),
      .load(fwake_load),
      .count({3'h0, func_wake_q}),
      .busy(fwake_busy)
   );

   att_settle u_lwake (
      .clk(clk),
      .nrst(nrst),
      .load(lwake_load),
      .count({3'h0, lp_wake_q}),
      .busy(lwake_busy)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ATT_STARTUP;
      end else begin
         case (state_q)
            ATT_STARTUP: begin
               if (!start_load_q && !start_busy) begin
                  state_q <= ATT_FUNC;
               end
            end
            ATT_FUNC, ATT_LOWPWR: begin
               if (sleep_req_q) begin
                  state_q <= ATT_SLEEP;
               end
            end
            ATT_SLEEP: begin
               if (fwake_load) begin
                  state_q <= ATT_WAKE_FUNC;
               end else if (lwake_load) begin
                  state_q <= ATT_WAKE_LP;
               end
            end
            ATT_WAKE_FUNC: begin
               if (!fwake_busy) begin
                  state_q <= ATT_FUNC;
               end
            end
            ATT_WAKE_LP: begin
               if (!lwake_busy) begin
                  state_q <= ATT_LOWPWR;
               end
            end
            default: begin
               state_q <= ATT_STARTUP;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         seq_reset <= 1'b1;
         dsp_reset <= 1'b1;
      end else begin
         seq_reset <= (state_q == ATT_STARTUP) || start_busy;
         dsp_reset <= (state_q == ATT_STARTUP) || lwake_busy;
      end
   end

   a_gain_zero_hold: assert property (
      gain_per_q == 16'h0000 |=> $stable(coarse_gain_dac))
      else $error("gain DAC changed with zero period");
   a_ofs_zero_hold: assert property (
      ofs_per_q == 16'h0000 && !coarse_ovr_q[OVR_EN_BIT]
      |=> $stable(offset_dac.coarse))
      else $error("offset DAC changed with zero period");
   a_coarse_force: assert property (
      coarse_ovr_q[15] |=> offset_dac.coarse == $past(coarse_ovr_q[7:0]))
      else $error("coarse override not applied");
   a_fine_force: assert property (
      fine_ovr_q[15] |=> offset_dac.fine == $past(fine_ovr_q[7:0]))
      else $error("fine override not applied");
   a_extrp_never: assert property (
      extrp_q == 16'h0000 && !extrap_run |=> !extrap_run)
      else $error("extrapolator ran with zero time");
   a_extrp_start: assert property (
      qual_d && !qual_q && extrp_q != 16'h0000 |=> extrap_run)
      else $error("extrapolator did not start");
   a_gain_spacing: assert property (
      gain_stb && gain_per_q == $past(gain_per_q) |=> !gain_stb [*8])
      else $error("gain updates too close");
   a_lp_wake_hold: assert property (
      lwake_load && lp_wake_q > 16'h0002 |=> ##1 dsp_reset)
      else $error("DSP reset not held on wake");
   a_func_wake_wait: assert property (
      fwake_load && func_wake_q > 16'h0002 |=> state_q == ATT_WAKE_FUNC [*2])
      else $error("functional wake skipped settle");

   c_startup_done: cover property ($fell(seq_reset));
   c_extrp_run: cover property ($fell(extrap_run));
   c_lp_wake: cover property (
      state_q == ATT_WAKE_LP ##1 state_q == ATT_LOWPWR);
   c_gain_update: cover property (gain_stb);
endmodule : att_regs

// *** att_pkg.sv ***
// Purpose: Shared constants and carriers for the AFE tuning timing block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Printed offsets are register indexes; byte address is index * 4
package att_pkg;

   // Tick is a fixed cycle count; it spans 2 us only on a 40 MHz clock
   localparam int unsigned TICK_CYC_INT = 80;
   localparam logic [6:0] TICK_CYC = TICK_CYC_INT[6:0];

   localparam logic [7:0] IDX_GAIN_PER = 8'h44;
   localparam logic [7:0] IDX_COARSE_OVR = 8'h45;
   localparam logic [7:0] IDX_FINE_OVR = 8'h46;
   localparam logic [7:0] IDX_OFS_PER = 8'h47;
   localparam logic [7:0] IDX_EXTRP = 8'h48;
   localparam logic [7:0] IDX_FUNC_WAKE = 8'h4C;
   localparam logic [7:0] IDX_START_HI = 8'h4D;
   localparam logic [7:0] IDX_START_LO = 8'h4E;
   localparam logic [7:0] IDX_LP_WAKE = 8'h4F;
   localparam logic [7:0] IDX_CTRL = 8'h60;
   localparam logic [7:0] IDX_STATUS = 8'h61;

   localparam logic [15:0] RST_GAIN_PER = 16'h01F4;
   localparam logic [15:0] RST_OVR = 16'h0000;
   localparam logic [15:0] RST_OFS_PER = 16'h01F4;
   localparam logic [15:0] RST_EXTRP = 16'h0000;
   localparam logic [15:0] RST_FUNC_WAKE = 16'h1000;
   localparam logic [2:0] RST_START_HI = 3'h6;
   localparam logic [15:0] RST_START_LO = 16'h1A80;
   localparam logic [15:0] RST_LP_WAKE = 16'h1000;

   localparam int unsigned OVR_EN_BIT = 15;
   localparam int unsigned CTRL_SLEEP_BIT = 0;
   localparam int unsigned CTRL_BATT_BIT = 1;
   localparam int unsigned CTRL_QUAL_BIT = 2;

   typedef enum logic [2:0] {
      ATT_STARTUP, ATT_FUNC, ATT_SLEEP, ATT_WAKE_FUNC, ATT_LOWPWR,
      ATT_WAKE_LP
   } att_state_e;

   typedef struct packed {
      logic [7:0] coarse;
      logic [7:0] fine;
   } att_offset_s;

endpackage : att_pkg

// *** att_tick.sv ***
// Purpose: Periodic strobe every period times a fixed tick
// Assumes: Period is sampled live; zero disables the strobe
// Notes: A change of period takes effect at the next tick, against the count in progress
module att_tick
   import att_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic [15:0] period,
   output logic strobe
);
   logic [6:0] sub_q;
   logic [15:0] cnt_q;
   logic tick;

   assign tick = (sub_q == TICK_CYC - 7'h01);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sub_q <= 7'h00;
      end else if (!run || period == 16'h0000 || tick) begin
         sub_q <= 7'h00;
      end else begin
         sub_q <= sub_q + 7'h01;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 16'h0000;
         strobe <= 1'b0;
      end else if (!run || period == 16'h0000) begin
         cnt_q <= 16'h0000;
         strobe <= 1'b0;
      end else if (tick) begin
         if (cnt_q + 16'h0001 >= period) begin
            cnt_q <= 16'h0000;
            strobe <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
            strobe <= 1'b0;
         end
      end else begin
         strobe <= 1'b0;
      end
   end
endmodule : att_tick

// *** att_settle.sv ***
// Purpose: One-shot down counter for settle waits
// Assumes: Load is a one-cycle pulse
// Notes: Busy stays high for exactly count cycles; zero count is no wait
module att_settle
   import att_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic load,
   input wire logic [18:0] count,
   output logic busy
);
   logic [18:0] cnt_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 19'h00000;
         busy <= 1'b0;
      end else if (load) begin
         cnt_q <= count;
         busy <= (count != 19'h00000);
      end else if (cnt_q > 19'h00001) begin
         cnt_q <= cnt_q - 19'h00001;
      end else begin
         cnt_q <= 19'h00000;
         busy <= 1'b0;
      end
   end
endmodule : att_settle

// *** att_regs_bench.sv ***
// Purpose: Self-checking bench for the AFE tuning timing register block
// Assumes: Zero-wait APB slave; a settle write in startup restarts the wait
// Notes: Startup is shortened by writing a small settle count first
module att_regs_bench
   import att_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [5:0] auto_coarse_gain, auto_fine_gain, coarse_gain_dac, fine_gain_dac;
   att_offset_s auto_offset, offset_dac;
   logic extrap_run, seq_reset, dsp_reset;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;
   int run_cyc = 0;
   int dsp_cyc = 0;
   logic [7:0] ri [9] = '{IDX_GAIN_PER, IDX_COARSE_OVR, IDX_FINE_OVR,
      IDX_OFS_PER, IDX_EXTRP, IDX_FUNC_WAKE, IDX_START_HI, IDX_START_LO,
      IDX_LP_WAKE};
   logic [15:0] rv [9] = '{RST_GAIN_PER, RST_OVR, RST_OVR, RST_OFS_PER,
      RST_EXTRP, RST_FUNC_WAKE, {13'h0, RST_START_HI}, RST_START_LO,
      RST_LP_WAKE};

   att_regs dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .auto_coarse_gain(auto_coarse_gain), .auto_fine_gain(auto_fine_gain),
      .auto_offset(auto_offset), .coarse_gain_dac(coarse_gain_dac),
      .fine_gain_dac(fine_gain_dac), .offset_dac(offset_dac),
      .extrap_run(extrap_run), .seq_reset(seq_reset), .dsp_reset(dsp_reset));

   always #10 clk = ~clk;

   // Level-high counters make pulse lengths immune to sampling phase
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (extrap_run === 1'b1) run_cyc <= run_cyc + 1;
      if (dsp_reset === 1'b1) dsp_cyc <= dsp_cyc + 1;
   end

   task automatic close_out();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Entered just after a rising edge; one idle edge after release
   task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      pstrb <= wr ? 4'h3 : 4'h0;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n >= 20) chk(32'h0, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      logic e;
      apb(1'b1, idx, wd, rd, e);
   endtask : wr

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp,
      input logic eerr);
      logic [31:0] rd;
      logic e;
      apb(1'b0, idx, 32'h0, rd, e);
      chk(rd, exp);
      chk({31'h0, e}, {31'h0, eerr});
   endtask : rdchk

   task automatic rdstate(input logic [2:0] exp);
      logic [31:0] rd;
      logic e;
      apb(1'b0, IDX_STATUS, 32'h0, rd, e);
      chk({29'h0, rd[2:0]}, {29'h0, exp});
   endtask : rdstate

   function automatic logic [31:0] dacv(input bit ofs);
      return ofs ? {16'h0, offset_dac}
         : {18'h0, coarse_gain_dac, 2'b00, fine_gain_dac};
   endfunction : dacv

   task automatic setauto(input bit ofs, input logic [15:0] v);
      if (ofs) begin
         auto_offset <= att_offset_s'(v);
      end else begin
         auto_coarse_gain <= v[13:8];
         auto_fine_gain <= v[5:0];
      end
   endtask : setauto

   task automatic waitdac(input bit ofs, input logic [15:0] v);
      int n;
      n = 0;
      while (dacv(ofs) !== {16'h0, v} && n < 60000) begin
         n++;
         @(posedge clk);
      end
      chk(dacv(ofs), {16'h0, v});
   endtask : waitdac

   task automatic t_startup();
      int c0;
      int el;
      for (int i = 0; i < 9; i++) rdchk(ri[i], {16'h0, rv[i]}, 1'b0);
      rdchk(8'h49, 32'h0, 1'b1);
      wr(IDX_GAIN_PER, 32'h3);
      wr(IDX_OFS_PER, 32'h2);
      wr(IDX_FUNC_WAKE, 32'h40);
      wr(IDX_LP_WAKE, 32'h30);
      // The reset count would take 400000 cycles; restart it at 64
      wr(IDX_START_HI, 32'h0);
      wr(IDX_START_LO, 32'h40);
      c0 = cyc;
      rdchk(IDX_START_LO, 32'h40, 1'b0);
      while (cyc - c0 < 60) @(posedge clk);
      chk({31'h0, seq_reset}, 32'h1);
      while (seq_reset !== 1'b0 && cyc - c0 < 200) @(posedge clk);
      el = cyc - c0;
      chk(32'(el >= 64 && el <= 72), 32'h1);
   endtask : t_startup

   task automatic t_period(input bit ofs, input logic [7:0] idx, input int per);
      int t1;
      setauto(ofs, 16'h1502);
      waitdac(ofs, 16'h1502);
      t1 = cyc;
      setauto(ofs, 16'h2A3C);
      waitdac(ofs, 16'h2A3C);
      chk(32'(cyc - t1), 32'(per * TICK_CYC_INT));
      wr(idx, 32'h0);
      setauto(ofs, 16'h0A11);
      repeat (per * 400) @(posedge clk);
      chk(dacv(ofs), 32'h2A3C);
      wr(idx, 32'(per));
   endtask : t_period

   task automatic t_override();
      wr(IDX_COARSE_OVR, 32'hFF80);
      wr(IDX_FINE_OVR, 32'h807F);
      rdchk(IDX_COARSE_OVR, 32'h8080, 1'b0);
      setauto(1'b1, 16'h1111);
      repeat (600) @(posedge clk);
      chk(dacv(1'b1), 32'h807F);
      wr(IDX_COARSE_OVR, 32'h0080);
      repeat (210) @(posedge clk);
      chk(dacv(1'b1), 32'h117F);
      wr(IDX_FINE_OVR, 32'h0);
      repeat (210) @(posedge clk);
      chk(dacv(1'b1), 32'h1111);
   endtask : t_override

   task automatic t_extrap();
      int r0;
      wr(IDX_EXTRP, 32'h2);
      r0 = run_cyc;
      wr(IDX_CTRL, 32'h4);
      repeat (400) @(posedge clk);
      chk(32'(run_cyc - r0), 32'(2 * TICK_CYC_INT));
      wr(IDX_CTRL, 32'h0);
      wr(IDX_EXTRP, 32'h0);
      wr(IDX_CTRL, 32'h4);
      repeat (50) @(posedge clk);
      chk(32'(run_cyc - r0), 32'(2 * TICK_CYC_INT));
      wr(IDX_CTRL, 32'h0);
   endtask : t_extrap

   task automatic t_sleep();
      int d0;
      wr(IDX_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      rdstate(3'h2);
      d0 = dsp_cyc;
      wr(IDX_CTRL, 32'h0);
      rdstate(3'h3);
      repeat (45) @(posedge clk);
      rdstate(3'h3);
      repeat (20) @(posedge clk);
      rdstate(3'h1);
      chk(32'(dsp_cyc - d0), 32'h0);
      wr(IDX_CTRL, 32'h3);
      repeat (3) @(posedge clk);
      rdstate(3'h2);
      d0 = dsp_cyc;
      wr(IDX_CTRL, 32'h2);
      repeat (100) @(posedge clk);
      chk(32'(dsp_cyc - d0), 32'h30);
      rdstate(3'h4);
   endtask : t_sleep

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      auto_coarse_gain = 6'h00;
      auto_fine_gain = 6'h00;
      auto_offset = '0;
      repeat (3) @(posedge clk);
      chk({30'h0, seq_reset, dsp_reset}, 32'h3);
      nrst <= 1'b1;
      t_startup();
      t_period(1'b0, IDX_GAIN_PER, 3);
      t_period(1'b1, IDX_OFS_PER, 2);
      t_override();
      t_extrap();
      t_sleep();
      close_out();
   end

   // All scenarios need about 4700 cycles; the margin covers slow DAC waits
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("watchdog expired at %0t", $time);
      close_out();
   end

endmodule : att_regs_bench
